/* jdp_defines.svh */
/*
  Constants of the debug-port master: clock figures, test-clock limits,
  hold times and the fixed scan patterns used to halt and resume the target.
  Assumes it is included by its bare name from every file that needs it.
*/
`ifndef JDP_DEFINES_SVH
`define JDP_DEFINES_SVH

// ----------------------------------------------------------------------------
// System clock and test-clock rates
// ----------------------------------------------------------------------------
`define JDP_SYS_CLK_KHZ 32'd10000
`define JDP_SPEED_MIN_KHZ 32'd391
`define JDP_SPEED_MAX_KHZ 32'd40000
`define JDP_SPEED_DEF_KHZ 32'd10000
`define JDP_STD_LIMIT_KHZ 32'd10000

// ----------------------------------------------------------------------------
// Times and their cycle counts (least times rounded up)
// ----------------------------------------------------------------------------
`define JDP_REQ_HOLD_NS 32'd1000
`define JDP_REQ_HOLD_CYC ((`JDP_REQ_HOLD_NS * `JDP_SYS_CLK_KHZ + 32'd999999) / 32'd1000000)
`define JDP_ACK_WAIT_US 32'd100
`define JDP_ACK_WAIT_CYC ((`JDP_ACK_WAIT_US * `JDP_SYS_CLK_KHZ + 32'd999) / 32'd1000)

// ----------------------------------------------------------------------------
// Fixed scan patterns, least significant bit shifted first
// ----------------------------------------------------------------------------
`define JDP_HALT_LEN 6'h04
`define JDP_HALT_TMS 32'h0000000c
`define JDP_HALT_TDI 32'h00000002
`define JDP_RESUME_LEN 6'h04
`define JDP_RESUME_TMS 32'h0000000c
`define JDP_RESUME_TDI 32'h00000004

`endif

/* jdp_pkg.sv */
/*
  Types of the debug-port master: command kinds, controller states and the
  packed state records of the scan engine and the returned-clock domain.
  Assumes nothing of its surroundings.
*/
package jdp_pkg;

  // --------------------------------------------------------------------------
  // Command kinds
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_BREAK = 3'h0,
    CMD_RESET = 3'h1,
    CMD_RUN = 3'h2,
    CMD_STEP = 3'h3,
    CMD_MEM = 3'h4,
    CMD_REG = 3'h5
  } jdp_cmd_t;

  // --------------------------------------------------------------------------
  // Controller states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_HALT = 5'h02,
    S_ACK = 5'h04,
    S_ACCESS = 5'h08,
    S_RESUME = 5'h10
  } jdp_state_t;

  // --------------------------------------------------------------------------
  // State of the returned-clock domain
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic run_s1;
    logic run_s2;
    logic tgl;
  } jdp_link_t;

  // --------------------------------------------------------------------------
  // State of the scan engine
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic busy;
    logic done;
    logic tck;
    logic tms;
    logic tdi;
    logic [5:0] len;
    logic [5:0] cnt;
    logic [31:0] tms_sr;
    logic [31:0] tdi_sr;
    logic [31:0] cap_sr;
    logic [31:0] tdo;
  } jdp_shift_t;

endpackage : jdp_pkg

/* jdp_shift_if.sv */
/*
  Carrier between the debug-port controller and its scan engine.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface jdp_shift_if #(parameter int W = 32);
  logic start;
  logic abort;
  logic tick;
  logic late;
  logic [5:0] len;
  logic [W-1:0] tms;
  logic [W-1:0] tdi;
  logic [W-1:0] tdo;
  logic busy;
  logic done;

  // Controller side.
  modport ctrl (output start, abort, tick, late, len, tms, tdi, input tdo, busy, done);
  // Scan engine side.
  modport engine (input start, abort, tick, late, len, tms, tdi, output tdo, busy, done);
endinterface : jdp_shift_if

`default_nettype wire

/* jdp_shifter.sv */
/*
  Scan engine: shifts up to 32 bits of TMS and TDI out on the test clock and
  captures TDO, either at the rising edge or late, just before the falling edge.
  Assumes tdo_sync_in is already synchronised and tick pulses pace each half period.
*/
`timescale 1ns/1ns
`default_nettype none

module jdp_shifter (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Controller link
  jdp_shift_if.engine sh,
  // Test port pins
  input wire logic tdo_sync_in,
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out
);

  jdp_pkg::jdp_shift_t r_reg;
  jdp_pkg::jdp_shift_t r_next;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  // Each tick flips the test clock; data changes only on the falling half.
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (sh.abort) begin
      r_next.busy = 1'b0;
      r_next.tck = 1'b0;
    end else if (sh.start && !r_reg.busy) begin
      r_next.busy = 1'b1;
      r_next.len = sh.len;
      r_next.cnt = sh.len;
      r_next.tms_sr = sh.tms;
      r_next.tdi_sr = sh.tdi;
      r_next.cap_sr = 32'h00000000;
      r_next.tms = sh.tms[0];
      r_next.tdi = sh.tdi[0];
      r_next.tck = 1'b0;
    end else if (r_reg.busy && sh.tick) begin
      if (!r_reg.tck) begin
        r_next.tck = 1'b1;
        if (!sh.late) begin
          r_next.cap_sr = {tdo_sync_in, r_reg.cap_sr[31:1]};
        end
      end else begin
        r_next.tck = 1'b0;
        if (sh.late) begin
          r_next.cap_sr = {tdo_sync_in, r_reg.cap_sr[31:1]};
        end
        r_next.tms_sr = r_reg.tms_sr >> 1;
        r_next.tdi_sr = r_reg.tdi_sr >> 1;
        r_next.tms = r_reg.tms_sr[1];
        r_next.tdi = r_reg.tdi_sr[1];
        r_next.cnt = r_reg.cnt - 6'h01;
        if (r_reg.cnt == 6'h01) begin
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
          r_next.tdo = (sh.late ? {tdo_sync_in, r_reg.cap_sr[31:1]} : r_reg.cap_sr) >> (6'h20 - r_reg.len);
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register.
  assign tck_out = r_reg.tck;
  assign tms_out = r_reg.tms;
  assign tdi_out = r_reg.tdi;
  assign sh.busy = r_reg.busy;
  assign sh.done = r_reg.done;
  assign sh.tdo = r_reg.tdo;

endmodule : jdp_shifter

`default_nettype wire

/* jdp_master.sv */
/*
  Debug-port master: drives the target's test port, paces the test clock from
  a divider or from the returned clock, bridges the debug handshake to the
  trigger-out and break-in connectors and enforces the real-time-only policy.
  Assumes configuration inputs come from logic on sys_clk_in; pins are asynchronous.
*/
// What this block does
// - With acknowledge enabled, the synchronised acknowledge pin tells at once when the target halts or resumes.
// - With acknowledge enabled, the acknowledge level is copied to the trigger-out connector.
// - With request enabled, a rising edge on break-in asserts the debug request to stop the target.
// - Acknowledge and request each have an enable that is off by default; when off the pin is ignored or undriven.
// - Without the real-time restriction, a memory or register access halts the running target and resumes it after.
// - With the real-time restriction, an access to a running target is rejected; break, reset, run and step pass.
// - The test clock comes from a divider of the own clock, the requested rate clamped between 391 kHz and 40 MHz.
// - A rate that cannot be made exactly is replaced by the nearest slower achievable rate.
// - In returned-clock mode each test-clock half period waits for an edge of the target's returned clock.
// - Switching between divided and returned clock resets all debug state, breakpoints included.
// - A requested rate of zero selects the default rate of 10 MHz.
// - With late sampling on, TDO is captured at the end of the high phase, allowing up to 40 MHz.
// - With late sampling off, TDO is captured at the rising edge as boundary-scan timing expects.
// - The divided test clock never depends on the target's clock.
`timescale 1ns/1ns
`default_nettype none
`include "jdp_defines.svh"

module jdp_master #(
  parameter int W = 32
) (
  // Clocks and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic rtck_clk_in,
  // Configuration
  input wire logic ack_enable_in,
  input wire logic req_enable_in,
  input wire logic rt_only_in,
  input wire logic rtck_mode_in,
  input wire logic late_sample_in,
  input wire logic [15:0] speed_khz_in,
  // Command port
  input wire logic cmd_valid_in,
  input wire jdp_pkg::jdp_cmd_t cmd_kind_in,
  input wire logic [5:0] cmd_len_in,
  input wire logic [W-1:0] cmd_tms_in,
  input wire logic [W-1:0] cmd_tdi_in,
  output logic cmd_ready_out,
  output logic cmd_done_out,
  output logic cmd_reject_out,
  output logic [W-1:0] cmd_tdo_out,
  // Breakpoint state
  input wire logic bkpt_set_in,
  output logic bkpt_armed_out,
  // Test port pins
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in,
  input wire logic dbg_ack_in,
  output logic debug_request_out,
  output logic debug_request_oe_out,
  // Connectors to other instruments
  input wire logic break_in_in,
  output logic trigger_out_out,
  // Status
  output logic halted_out,
  output logic halt_edge_out,
  output logic reinit_out,
  output logic over_limit_out,
  output logic [15:0] speed_khz_out
);

  // ----------------------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------------------
  typedef struct packed {
    jdp_pkg::jdp_state_t state;
    jdp_pkg::jdp_cmd_t kind;
    logic resume;
    logic halted_soft;
    logic halted_d;
    logic mode_prev;
    logic bkpt;
    logic req;
    logic [31:0] req_cnt;
    logic [31:0] ack_cnt;
    logic [31:0] div_cnt;
    logic ack_s1;
    logic ack_s2;
    logic brk_s1;
    logic brk_s2;
    logic brk_d;
    logic tdo_s1;
    logic tdo_s2;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_d;
    logic sh_start;
    logic [5:0] sh_len;
    logic [W-1:0] sh_tms;
    logic [W-1:0] sh_tdi;
    logic done;
    logic reject;
    logic [W-1:0] tdo;
    logic halt_edge;
    logic reinit;
    logic trig;
    logic over;
    logic [15:0] speed;
  } jdp_master_t;

  jdp_master_t r_reg;
  jdp_master_t r_next;
  jdp_pkg::jdp_link_t l_reg;
  jdp_pkg::jdp_link_t l_next;
  jdp_shift_if #(.W(W)) sh ();

  logic [31:0] khz_c;
  logic [31:0] half_c;
  logic [31:0] real_c;
  logic div_tick;
  logic rt_tick;
  logic halted_c;
  logic needs_halt;
  logic rt_run;

  // ----------------------------------------------------------------------------
  // Test-clock rate
  // ----------------------------------------------------------------------------
  // Clamp the request, then round the half period up so the rate only drops.
  always_comb begin
    khz_c = (speed_khz_in == 16'h0000) ? `JDP_SPEED_DEF_KHZ : {16'h0000, speed_khz_in};
    if (khz_c < `JDP_SPEED_MIN_KHZ) begin
      khz_c = `JDP_SPEED_MIN_KHZ;
    end else if (khz_c > `JDP_SPEED_MAX_KHZ) begin
      khz_c = `JDP_SPEED_MAX_KHZ;
    end
    half_c = (`JDP_SYS_CLK_KHZ + (khz_c << 1) - 32'd1) / (khz_c << 1);
    if (half_c == 32'd0) begin
      half_c = 32'd1;
    end
    real_c = `JDP_SYS_CLK_KHZ / (half_c << 1);
  end

  // Divider ticks run only from the own clock; returned-clock ticks from the crossing.
  assign div_tick = !rtck_mode_in && (r_reg.div_cnt == 32'd0);
  assign rt_tick = rtck_mode_in && (r_reg.tgl_s2 != r_reg.tgl_d);
  assign rt_run = rtck_mode_in && sh.busy;
  assign halted_c = ack_enable_in ? r_reg.ack_s2 : r_reg.halted_soft;
  assign needs_halt = (cmd_kind_in == jdp_pkg::CMD_MEM) || (cmd_kind_in == jdp_pkg::CMD_REG);

  // ----------------------------------------------------------------------------
  // Controller next state
  // ----------------------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.sh_start = 1'b0;
    r_next.done = 1'b0;
    r_next.reject = 1'b0;
    r_next.reinit = 1'b0;
    // Two-flop synchronisers for every pin and for the returned-clock toggle.
    r_next.ack_s1 = dbg_ack_in;
    r_next.ack_s2 = r_reg.ack_s1;
    r_next.brk_s1 = break_in_in;
    r_next.brk_s2 = r_reg.brk_s1;
    r_next.brk_d = r_reg.brk_s2;
    r_next.tdo_s1 = tdo_in;
    r_next.tdo_s2 = r_reg.tdo_s1;
    r_next.tgl_s1 = l_reg.tgl;
    r_next.tgl_s2 = r_reg.tgl_s1;
    r_next.tgl_d = r_reg.tgl_s2;
    r_next.halted_d = halted_c;
    r_next.halt_edge = halted_c != r_reg.halted_d;
    r_next.trig = ack_enable_in && r_reg.ack_s2;
    r_next.speed = real_c[15:0];
    r_next.over = !late_sample_in && (real_c > `JDP_STD_LIMIT_KHZ);
    r_next.div_cnt = (r_reg.div_cnt == 32'd0 || !sh.busy) ? half_c - 32'd1 : r_reg.div_cnt - 32'd1;
    if (bkpt_set_in) begin
      r_next.bkpt = 1'b1;
    end
    // Debug request: set by break-in, held to acknowledge or for a fixed time.
    if (r_reg.req) begin
      if (ack_enable_in) begin
        r_next.req = !r_reg.ack_s2;
      end else if (r_reg.req_cnt == 32'd0) begin
        r_next.req = 1'b0;
      end else begin
        r_next.req_cnt = r_reg.req_cnt - 32'd1;
      end
    end
    if (req_enable_in && r_reg.brk_s2 && !r_reg.brk_d) begin
      r_next.req = 1'b1;
      r_next.req_cnt = `JDP_REQ_HOLD_CYC - 32'd1;
    end
    unique case (r_reg.state)
      jdp_pkg::S_IDLE: begin
        if (cmd_valid_in) begin
          r_next.kind = cmd_kind_in;
          r_next.sh_len = cmd_len_in;
          r_next.sh_tms = cmd_tms_in;
          r_next.sh_tdi = cmd_tdi_in;
          r_next.resume = 1'b0;
          if ((needs_halt || cmd_kind_in == jdp_pkg::CMD_BREAK) && !halted_c) begin
            if (needs_halt && rt_only_in) begin
              r_next.reject = 1'b1;
            end else begin
              r_next.resume = needs_halt;
              r_next.ack_cnt = `JDP_ACK_WAIT_CYC;
              if (req_enable_in) begin
                r_next.req = 1'b1;
                r_next.req_cnt = `JDP_REQ_HOLD_CYC - 32'd1;
                r_next.state = jdp_pkg::S_ACK;
              end else begin
                r_next.sh_start = 1'b1;
                r_next.sh_len = `JDP_HALT_LEN;
                r_next.sh_tms = W'(`JDP_HALT_TMS);
                r_next.sh_tdi = W'(`JDP_HALT_TDI);
                r_next.state = jdp_pkg::S_HALT;
              end
            end
          end else if (cmd_kind_in == jdp_pkg::CMD_BREAK) begin
            r_next.done = 1'b1;
          end else begin
            r_next.sh_start = 1'b1;
            r_next.state = jdp_pkg::S_ACCESS;
          end
        end
      end
      jdp_pkg::S_HALT: begin
        if (sh.done) begin
          r_next.state = jdp_pkg::S_ACK;
        end
      end
      jdp_pkg::S_ACK: begin
        // With acknowledge the halt is confirmed by the pin or assumed once the wait runs out, else assumed.
        r_next.ack_cnt = r_reg.ack_cnt - 32'd1;
        if (!ack_enable_in || r_reg.ack_s2 || r_reg.ack_cnt == 32'd0) begin
          r_next.halted_soft = 1'b1;
          if (r_reg.kind == jdp_pkg::CMD_BREAK) begin
            r_next.done = 1'b1;
            r_next.state = jdp_pkg::S_IDLE;
          end else begin
            r_next.sh_start = 1'b1;
            r_next.sh_len = cmd_len_in;
            r_next.sh_tms = cmd_tms_in;
            r_next.sh_tdi = cmd_tdi_in;
            r_next.state = jdp_pkg::S_ACCESS;
          end
        end
      end
      jdp_pkg::S_ACCESS: begin
        if (sh.done) begin
          r_next.tdo = sh.tdo;
          if (r_reg.kind == jdp_pkg::CMD_RUN || r_reg.kind == jdp_pkg::CMD_STEP ||
              r_reg.kind == jdp_pkg::CMD_RESET) begin
            r_next.halted_soft = 1'b0;
          end
          if (r_reg.resume) begin
            r_next.sh_start = 1'b1;
            r_next.sh_len = `JDP_RESUME_LEN;
            r_next.sh_tms = W'(`JDP_RESUME_TMS);
            r_next.sh_tdi = W'(`JDP_RESUME_TDI);
            r_next.state = jdp_pkg::S_RESUME;
          end else begin
            r_next.done = 1'b1;
            r_next.state = jdp_pkg::S_IDLE;
          end
        end
      end
      jdp_pkg::S_RESUME: begin
        if (sh.done) begin
          r_next.halted_soft = 1'b0;
          r_next.done = 1'b1;
          r_next.state = jdp_pkg::S_IDLE;
        end
      end
    endcase
    // A change of clock source wipes all debug state, breakpoints too.
    r_next.mode_prev = rtck_mode_in;
    if (rtck_mode_in != r_reg.mode_prev) begin
      r_next.reinit = 1'b1;
      r_next.state = jdp_pkg::S_IDLE;
      r_next.bkpt = 1'b0;
      r_next.req = 1'b0;
      r_next.halted_soft = 1'b0;
      r_next.resume = 1'b0;
      r_next.sh_start = 1'b0;
      r_next.done = 1'b0;
      r_next.tdo = '0;
    end
  end

  // ----------------------------------------------------------------------------
  // Controller state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      r_reg <= '0;
      r_reg.state <= jdp_pkg::S_IDLE;
      r_reg.speed <= 16'h2710;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Returned-clock domain
  // ----------------------------------------------------------------------------
  // One toggle per rising returned-clock edge while a scan runs paces the test clock.
  always_comb begin
    l_next = l_reg;
    l_next.rst_s1 = rstn_in;
    l_next.rst_s2 = l_reg.rst_s1;
    l_next.run_s1 = rt_run;
    l_next.run_s2 = l_reg.run_s1;
    if (!l_reg.rst_s2) begin
      l_next.tgl = 1'b0;
    end else if (l_reg.run_s2) begin
      l_next.tgl = !l_reg.tgl;
    end
  end

  always_ff @(posedge rtck_clk_in) begin
    l_reg <= l_next;
  end

  // ----------------------------------------------------------------------------
  // Scan engine
  // ----------------------------------------------------------------------------
  assign sh.start = r_reg.sh_start;
  assign sh.abort = r_reg.reinit;
  assign sh.tick = div_tick || rt_tick;
  assign sh.late = late_sample_in;
  assign sh.len = r_reg.sh_len;
  assign sh.tms = r_reg.sh_tms;
  assign sh.tdi = r_reg.sh_tdi;

  jdp_shifter u_shifter (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .sh(sh.engine),
    .tdo_sync_in(r_reg.tdo_s2),
    .tck_out(tck_out),
    .tms_out(tms_out),
    .tdi_out(tdi_out)
  );

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign cmd_ready_out = (r_reg.state == jdp_pkg::S_IDLE) && (rtck_mode_in == r_reg.mode_prev);
  assign cmd_done_out = r_reg.done;
  assign cmd_reject_out = r_reg.reject;
  assign cmd_tdo_out = r_reg.tdo;
  assign bkpt_armed_out = r_reg.bkpt;
  assign debug_request_out = r_reg.req && req_enable_in;
  assign debug_request_oe_out = req_enable_in;
  assign trigger_out_out = r_reg.trig;
  assign halted_out = r_reg.halted_d;
  assign halt_edge_out = r_reg.halt_edge;
  assign reinit_out = r_reg.reinit;
  assign over_limit_out = r_reg.over;
  assign speed_khz_out = r_reg.speed;

endmodule : jdp_master

`default_nettype wire

/* jdp_asserts.sv */
/* Checker of the debug-port master, seeing only its top ports.
   Assumes it is bound to jdp_master from the bench. */
`timescale 1ns/1ns
`default_nettype none
module jdp_asserts (
  // Watched ports
  input wire logic sys_clk_in, rstn_in, ack_enable_in, req_enable_in, rt_only_in,
  input wire logic rtck_mode_in, cmd_valid_in, cmd_ready_out, cmd_reject_out,
  input wire jdp_pkg::jdp_cmd_t cmd_kind_in,
  input wire logic dbg_ack_in, debug_request_out, debug_request_oe_out, break_in_in,
  input wire logic trigger_out_out, halted_out, reinit_out, bkpt_armed_out, halt_edge_out
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // A command taken, and a rise of the acknowledge pin while it is used.
  sequence s_take;
    cmd_valid_in && cmd_ready_out;
  endsequence
  sequence s_ack_rise;
    ack_enable_in && $rose(dbg_ack_in);
  endsequence
  chk_oe_follow: assert property (debug_request_oe_out == req_enable_in) else $error("oe wrong");
  chk_req_gated: assert property (!req_enable_in |-> !debug_request_out) else $error("req driven");
  chk_trig_off: assert property (!ack_enable_in |=> !trigger_out_out) else $error("trigger set");
  chk_trig_copy: assert property (s_ack_rise |-> ##[1:4] trigger_out_out) else $error("no trigger");
  chk_halt_seen: assert property (s_ack_rise |-> ##[1:4] halted_out) else $error("halt unseen");
  chk_breakin_req: assert property (req_enable_in && $rose(break_in_in) |-> ##[1:6] debug_request_out)
    else $error("no request");
  chk_edge_pulse: assert property (halt_edge_out == $changed(halted_out)) else $error("edge wrong");
  chk_req_hold: assert property ($fell(debug_request_out) && ack_enable_in && req_enable_in && !reinit_out
    |-> $past(dbg_ack_in, 2) || $past(dbg_ack_in, 3) || $past(dbg_ack_in, 4)) else $error("req early");
  chk_reject_cause: assert property (s_take ##0 (rt_only_in && !halted_out && cmd_kind_in >= jdp_pkg::CMD_MEM)
    |=> cmd_reject_out) else $error("no reject");
  chk_ctl_pass: assert property (s_take ##0 (cmd_kind_in < jdp_pkg::CMD_MEM) |=> !cmd_reject_out)
    else $error("bad reject");
  chk_reinit_edge: assert property ($changed(rtck_mode_in) |-> ##[0:2] reinit_out) else $error("no reinit");
  chk_bkpt_clear: assert property (reinit_out |-> ##[0:1] !bkpt_armed_out) else $error("bkpt kept");
endmodule : jdp_asserts
`default_nettype wire

/* jdp_target_model.sv */
/* Target model: debug handshake, constant TDO and a returned clock.
   Assumes run_in is high during reset and while a scan runs in returned-clock mode. */
`timescale 1ns/1ns
`default_nettype none
module jdp_target_model (
  // Master side and bench controls
  input wire logic sys_clk_in, debug_request_out, go_in, run_in, tdo_val_in,
  // Pins towards the master
  output logic dbg_ack_in, tdo_in, rtck_clk_in
);
  logic [2:0] dly_reg;
  // Start idle and running.
  initial begin
    {dly_reg, dbg_ack_in, rtck_clk_in} = 5'h0;
  end
  // Halt four cycles after a request; resume on go.
  always @(posedge sys_clk_in) begin
    dly_reg <= {dly_reg[1:0], debug_request_out};
    if (go_in) dbg_ack_in <= 1'b0;
    else if (dly_reg[2]) dbg_ack_in <= 1'b1;
  end
  // The returned clock runs only within scans and reset, 12 ns period.
  always begin
    #6;
    if (run_in) rtck_clk_in = ~rtck_clk_in;
  end
  assign tdo_in = tdo_val_in;
endmodule : jdp_target_model
`default_nettype wire

/* tb_top.sv */
/* Bench of the debug-port master against the target model.
   Assumes the package, model and checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic sys_clk_in, rstn_in, rtck_clk_in, ack_enable_in, req_enable_in, rt_only_in;
  logic rtck_mode_in, late_sample_in, cmd_valid_in, cmd_ready_out, cmd_done_out, cmd_reject_out;
  logic bkpt_set_in, bkpt_armed_out, tck_out, tms_out, tdi_out, tdo_in, dbg_ack_in, go, tdo_val;
  logic debug_request_out, debug_request_oe_out, break_in_in, trigger_out_out, halted_out;
  logic halt_edge_out, reinit_out, over_limit_out;
  logic [15:0] speed_khz_in, speed_khz_out;
  logic [5:0] cmd_len_in;
  logic [31:0] cmd_tms_in, cmd_tdi_in, cmd_tdo_out;
  logic [64:0] q[$];
  logic [64:0] n;
  jdp_pkg::jdp_cmd_t cmd_kind_in;
  int fails = 0;
  int samples_checked = 0;
  int s, h;
  // ----
  // Design, target and clock
  // ----
  jdp_master dut (.*);
  // The returned clock also runs under reset so that the link flops of the design are cleared.
  jdp_target_model tgt (.sys_clk_in, .debug_request_out, .go_in(go),
    .run_in(!rstn_in || (rtck_mode_in && !cmd_ready_out)),
    .tdo_val_in(tdo_val), .dbg_ack_in, .tdo_in, .rtck_clk_in);
  // System clock of 100 ns.
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  // Compare one value with its expectation.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Print the verdict and end the run.
  task automatic print_verdict();
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  // Offer one command, note its answer and wait for it.
  task automatic do_cmd(input jdp_pkg::jdp_cmd_t k, input logic rej, input int len);
    logic [31:0] m;
    int i;
    m = (k >= jdp_pkg::CMD_MEM && !rej) ? 32'hffffffff >> (32 - len) : 32'h0;
    q.push_back({rej, m, tdo_val ? m : 32'h0});
    cmd_kind_in = k;
    cmd_len_in = 6'(len);
    cmd_tms_in = $urandom;
    cmd_tdi_in = $urandom;
    cmd_valid_in = 1'b1;
    for (i = 0; i < 50 && cmd_ready_out !== 1'b1; i++) @(negedge sys_clk_in);
    @(negedge sys_clk_in);
    cmd_valid_in = 1'b0;
    for (i = 0; i < 3000 && cmd_done_out !== 1'b1 && cmd_reject_out !== 1'b1; i++) @(negedge sys_clk_in);
    if (i == 3000) begin
      fails++;
      print_verdict();
    end
    @(negedge sys_clk_in);
  endtask : do_cmd
  // Check each answer against the oldest note.
  always @(negedge sys_clk_in) begin
    if (cmd_done_out === 1'b1 || cmd_reject_out === 1'b1) begin
      n = q.size() > 0 ? q.pop_front() : {1'b1, 64'h0};
      check(cmd_reject_out, n[64]);
      check(cmd_tdo_out & n[63:32], n[31:0]);
    end
  end
  // Main sequence.
  initial begin
    void'($urandom(32'hc494));
    {rstn_in, ack_enable_in, req_enable_in, rt_only_in, rtck_mode_in, late_sample_in} = 6'h0;
    {cmd_valid_in, bkpt_set_in, break_in_in, go, tdo_val, cmd_len_in} = 11'h001;
    {speed_khz_in, cmd_tms_in, cmd_tdi_in} = {16'h2710, 64'h0};
    cmd_kind_in = jdp_pkg::CMD_BREAK;
    repeat (16) @(negedge sys_clk_in);
    rstn_in = 1'b1;
    check(speed_khz_out, 32'h2710);
    check({debug_request_out, debug_request_oe_out, trigger_out_out}, 32'h0);
    rt_only_in = 1'b1;
    for (int k = 1; k < 7; k++) do_cmd(jdp_pkg::jdp_cmd_t'(k % 6), k == 4 || k == 5, 8);
    do_cmd(jdp_pkg::CMD_MEM, 1'b0, 32);
    do_cmd(jdp_pkg::CMD_RUN, 1'b0, 4);
    // Random rates, each followed by a halting access; late sampling last.
    rt_only_in = 1'b0;
    for (int r = 0; r < 3; r++) begin
      s = 1000 + $urandom % 9001;
      h = (10000 + 2 * s - 1) / (2 * s);
      speed_khz_in = 16'(s);
      late_sample_in = r == 2;
      tdo_val = 1'($urandom);
      for (int i = 0; i < 20 && speed_khz_out !== 16'(10000 / (2 * h)); i++) @(negedge sys_clk_in);
      check(speed_khz_out, 10000 / (2 * h));
      check(over_limit_out, 32'h0);
      do_cmd(jdp_pkg::CMD_MEM, 1'b0, 1 + $urandom % 32);
      check(halted_out, 32'h0);
    end
    // Break-in, handshake and trigger-out.
    {ack_enable_in, req_enable_in, break_in_in} = 3'h7;
    for (int i = 0; i < 40 && halted_out !== 1'b1; i++) @(negedge sys_clk_in);
    check({halted_out, trigger_out_out}, 32'h3);
    break_in_in = 1'b0;
    for (int i = 0; i < 12 && debug_request_out !== 1'b0; i++) @(negedge sys_clk_in);
    check(debug_request_out, 32'h0);
    go = 1'b1;
    @(negedge sys_clk_in);
    go = 1'b0;
    for (int i = 0; i < 12 && halted_out !== 1'b0; i++) @(negedge sys_clk_in);
    check(trigger_out_out, 32'h0);
    do_cmd(jdp_pkg::CMD_BREAK, 1'b0, 4);
    check(halted_out, 32'h1);
    {ack_enable_in, req_enable_in, go, bkpt_set_in} = 4'h3;
    @(negedge sys_clk_in);
    {go, bkpt_set_in} = 2'h0;
    @(negedge sys_clk_in);
    check(bkpt_armed_out, 32'h1);
    // Clock-source change, then an access paced by the returned clock.
    rtck_mode_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    check(bkpt_armed_out, 32'h0);
    do_cmd(jdp_pkg::CMD_MEM, 1'b0, 8);
    print_verdict();
  end
endmodule : tb_top
bind jdp_master jdp_asserts u_chk (.*);
`default_nettype wire
